// ### hsic_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor model driving the register port of the hub
module hsic_host_model (
   input  wire logic       ref_clk,   // Hub clock
   output logic      [7:0] reg_addr,  // Register offset
   output logic      [7:0] reg_wdata, // Write data
   output logic            reg_wr,    // Write strobe
   output logic            reg_rd     // Read strobe
);
   // Idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One write, held for exactly one taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // One read; data is taken by the bench watcher
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### hsic_pkg.sv
package hsic_pkg;
   // Register offsets on the serial register port
   localparam logic [7:0] OFS_EVENT_STATUS = 8'he8;
   localparam logic [7:0] OFS_EVENT_ENABLE = 8'he9;
   localparam logic [7:0] OFS_ADDR_LOW_SEL = 8'hea;
   localparam logic [7:0] OFS_ADDR_HIGH_SEL = 8'heb;
   localparam logic [7:0] OFS_CHG_CONTROL = 8'hec;
   localparam logic [7:0] OFS_CHG_TYPE_EN = 8'hed;
   // Field positions
   localparam int BIT_IRQ_ACTIVE = 7;
   localparam int BIT_SUSPEND = 4;
   localparam int BIT_HOST_CFG = 3;
   localparam int BIT_PORT_PWR = 2;
   localparam int BIT_CHG_FOUND = 1;
   localparam int BIT_DET_DONE = 0;
   localparam int BIT_AUTO_DET = 4;
   localparam int BIT_ENH_DET = 2;
   localparam int BIT_CDP_EN = 1;
   localparam int BIT_DCP_EN = 0;
   localparam int NUM_EVENTS = 5;
   // Reset values
   localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
   localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
   localparam logic [7:0] RST_ADDR_LOW_SEL = 8'h08;
   localparam logic [7:0] RST_ADDR_HIGH_SEL = 8'h28;
   localparam logic [7:0] RST_CHG_CONTROL = 8'h14;
   localparam logic [7:0] RST_CHG_TYPE_EN = 8'h0f;
   // Writable or readable field masks; other bits read zero, except status bit 7, which reads the top bit
   localparam logic [7:0] MASK_EVENTS = 8'h1f;
   localparam logic [7:0] MASK_CHG_CONTROL = 8'h14;
   localparam logic [7:0] MASK_CHG_TYPE_EN = 8'h0f;
endpackage

// ### hsic_serial_irq.sv
`timescale 1ns/10ps
`default_nettype none
module hsic_serial_irq (
   input  wire logic       ref_clk,                   // 40 MHz hub clock
   input  wire logic       rst,                       // Async reset, active high
   input  wire logic [7:0] reg_addr,                  // Register offset
   input  wire logic [7:0] reg_wdata,                 // Write data
   input  wire logic       reg_wr,                    // Write strobe
   input  wire logic       reg_rd,                    // Read strobe
   output logic      [7:0] reg_rdata,                 // Read data, next cycle
   input  wire logic       hub_in_suspend,            // Hub suspended level
   input  wire logic       host_configured,           // Host configured pulse
   input  wire logic       port_power_updated,        // Port power write pulse
   input  wire logic       detect_finished,           // Detection complete level
   input  wire logic       charging_downstream_port,  // Detected pulse
   input  wire logic       dedicated_charging_port,   // Detected pulse
   input  wire logic       chg_det_stage_entry,       // Stage entry pulse
   input  wire logic       wait_refclk_stage,         // In ref clock wait
   input  wire logic       ref_clk_absent,            // No reference clock
   input  wire logic       irq_pin_suspend_level_sel, // Pin shows suspend level
   input  wire logic       addr_select_lsb_pin,       // Async pin
   input  wire logic       addr_select_msb_pin,       // Async pin
   output logic            irq_n,                     // Interrupt pin, active low
   output logic            charger_found_low,         // Charger indicator, active low
   output logic            detect_start,              // Start detection pulse
   output logic            vdat_src_reverse,          // Reverse data-line source
   output logic            auto_detect_en,            // Detection enabled
   output logic            enhanced_detect_en,        // Enhanced detection
   output logic      [6:0] slave_address              // Serial slave address
);
   localparam int NE = hsic_pkg::NUM_EVENTS;

   // Pin synchronisers
   logic [1:0] pin_meta_q, pin_meta_d;  // First stage
   logic [1:0] pin_sync_q, pin_sync_d;  // Second stage

   // Event and interrupt state
   logic [NE-1:0] flags_q, flags_d;     // Sticky event flags
   logic [NE-1:0] enable_q, enable_d;   // Event enables
   logic          irq_active_q, irq_active_d; // Top status bit
   logic          susp_prev_q, susp_prev_d;   // Suspend edge history
   logic          done_prev_q, done_prev_d;   // Done edge history
   logic [NE-1:0] ev_set;               // Events this cycle
   logic          wr_status;            // Status write strobe

   // Charger configuration and indicator
   logic [7:0] chg_ctrl_q, chg_ctrl_d;  // Charger control
   logic [7:0] chg_type_q, chg_type_d;  // Charger type enables
   logic       chg_low_q, chg_low_d;    // Charger found indicator
   logic       start_q, start_d;        // Start pulse
   logic       wait_prev_q, wait_prev_d; // Wait stage history

   // Read data
   logic [7:0] rdata_q, rdata_d;        // Registered read data
   logic [7:0] rd_mux;                  // Selected register

   // Pin synchroniser next state
   always_comb begin
      pin_meta_d = {addr_select_msb_pin, addr_select_lsb_pin};
      pin_sync_d = pin_meta_q;
   end

   // Pin synchroniser registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_meta_q <= 2'h0;
         pin_sync_q <= 2'h0;
      end else begin
         pin_meta_q <= pin_meta_d;
         pin_sync_q <= pin_sync_d;
      end
   end

   // Slave address from selected register and LSB pin
   always_comb begin
      if (pin_sync_q[1]) begin
         slave_address = {hsic_pkg::RST_ADDR_HIGH_SEL[6:1], pin_sync_q[0]};
      end else begin
         slave_address = {hsic_pkg::RST_ADDR_LOW_SEL[6:1], pin_sync_q[0]};
      end
   end

   // Event detection, sticky flags, enables and top bit
   always_comb begin
      wr_status = reg_wr && (reg_addr == hsic_pkg::OFS_EVENT_STATUS);
      susp_prev_d = hub_in_suspend;
      done_prev_d = detect_finished;
      ev_set = '0;
      ev_set[hsic_pkg::BIT_SUSPEND] = hub_in_suspend & ~susp_prev_q;
      ev_set[hsic_pkg::BIT_HOST_CFG] = host_configured;
      ev_set[hsic_pkg::BIT_PORT_PWR] = port_power_updated;
      ev_set[hsic_pkg::BIT_CHG_FOUND] = chg_low_q & ~chg_low_d;
      ev_set[hsic_pkg::BIT_DET_DONE] = detect_finished & ~done_prev_q;
      // Zero bits clear, one bits keep; new events win over the clear
      flags_d = flags_q;
      if (wr_status) begin
         flags_d = flags_q & reg_wdata[NE-1:0];
      end
      flags_d = flags_d | ev_set;
      // Enable register, reserved bits dropped
      enable_d = enable_q;
      if (reg_wr && (reg_addr == hsic_pkg::OFS_EVENT_ENABLE)) begin
         enable_d = reg_wdata[NE-1:0];
      end
      // Top bit holds until a zero write; a fresh enabled event wins
      irq_active_d = irq_active_q;
      if (wr_status && !reg_wdata[hsic_pkg::BIT_IRQ_ACTIVE]) begin
         irq_active_d = 1'b0;
      end
      if (|(ev_set & enable_q)) begin
         irq_active_d = 1'b1;
      end
   end

   // Event registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flags_q      <= hsic_pkg::RST_EVENT_STATUS[NE-1:0];
         enable_q     <= hsic_pkg::RST_EVENT_ENABLE[NE-1:0];
         irq_active_q <= hsic_pkg::RST_EVENT_STATUS[hsic_pkg::BIT_IRQ_ACTIVE];
         susp_prev_q  <= 1'b0;
         done_prev_q  <= 1'b0;
      end else begin
         flags_q      <= flags_d;
         enable_q     <= enable_d;
         irq_active_q <= irq_active_d;
         susp_prev_q  <= susp_prev_d;
         done_prev_q  <= done_prev_d;
      end
   end

   // Pin follows top bit, or the suspend level when selected
   always_comb begin
      if (irq_pin_suspend_level_sel) begin
         irq_n = ~susp_prev_q;
      end else begin
         irq_n = ~irq_active_q;
      end
   end

   // Charger configuration, start pulse and indicator
   always_comb begin
      chg_ctrl_d = chg_ctrl_q;
      if (reg_wr && (reg_addr == hsic_pkg::OFS_CHG_CONTROL)) begin
         chg_ctrl_d = reg_wdata & hsic_pkg::MASK_CHG_CONTROL;
      end
      chg_type_d = chg_type_q;
      if (reg_wr && (reg_addr == hsic_pkg::OFS_CHG_TYPE_EN)) begin
         chg_type_d = reg_wdata & hsic_pkg::MASK_CHG_TYPE_EN;
      end
      wait_prev_d = wait_refclk_stage & ref_clk_absent;
      // Start once per stage entry, or on entering a clockless wait
      start_d = chg_ctrl_q[hsic_pkg::BIT_AUTO_DET]
                & (chg_det_stage_entry | (wait_prev_d & ~wait_prev_q));
      // A new run releases the indicator; enabled detections pull it low
      chg_low_d = chg_low_q;
      if (start_q) begin
         chg_low_d = 1'b1;
      end
      if ((charging_downstream_port && chg_type_q[hsic_pkg::BIT_CDP_EN])
          || (dedicated_charging_port && chg_type_q[hsic_pkg::BIT_DCP_EN])) begin
         chg_low_d = 1'b0;
      end
   end

   // Charger registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         chg_ctrl_q  <= hsic_pkg::RST_CHG_CONTROL;
         chg_type_q  <= hsic_pkg::RST_CHG_TYPE_EN;
         chg_low_q   <= 1'b1;
         start_q     <= 1'b0;
         wait_prev_q <= 1'b0;
      end else begin
         chg_ctrl_q  <= chg_ctrl_d;
         chg_type_q  <= chg_type_d;
         chg_low_q   <= chg_low_d;
         start_q     <= start_d;
         wait_prev_q <= wait_prev_d;
      end
   end

   // Configuration outputs
   always_comb begin
      charger_found_low  = chg_low_q;
      detect_start       = start_q;
      auto_detect_en     = chg_ctrl_q[hsic_pkg::BIT_AUTO_DET];
      enhanced_detect_en = chg_ctrl_q[hsic_pkg::BIT_ENH_DET];
      vdat_src_reverse   = chg_ctrl_q[hsic_pkg::BIT_ENH_DET];
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      case (reg_addr)
         hsic_pkg::OFS_EVENT_STATUS: begin
            rd_mux = {irq_active_q, 2'h0, flags_q};
         end
         hsic_pkg::OFS_EVENT_ENABLE: begin
            rd_mux = {3'h0, enable_q};
         end
         hsic_pkg::OFS_ADDR_LOW_SEL: begin
            rd_mux = hsic_pkg::RST_ADDR_LOW_SEL;
         end
         hsic_pkg::OFS_ADDR_HIGH_SEL: begin
            rd_mux = hsic_pkg::RST_ADDR_HIGH_SEL;
         end
         hsic_pkg::OFS_CHG_CONTROL: begin
            rd_mux = chg_ctrl_q;
         end
         hsic_pkg::OFS_CHG_TYPE_EN: begin
            rd_mux = chg_type_q;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
      rdata_d = reg_rd ? rd_mux : rdata_q;
   end

   // Read data register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // Checks on the block's outputs and its internal status registers
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_pin_top_bit: assert property (
      !irq_pin_suspend_level_sel |-> (irq_n == !irq_active_q))
      else $error("Pin disagrees with top status bit");
   a_top_release: assert property (
      (wr_status && !reg_wdata[7] && !(|(ev_set & enable_q)))
      |=> !irq_active_q && (irq_pin_suspend_level_sel || irq_n))
      else $error("Zero write did not release pin");
   a_one_write_keep: assert property (
      (wr_status && reg_wdata == 8'hff) |=> (flags_q == $past(flags_q | ev_set))
      && (irq_active_q || !$past(irq_active_q)))
      else $error("One write changed status");
   a_suspend_flag: assert property (
      (hub_in_suspend && !susp_prev_q) |=> flags_q[4] ##1 (flags_q[4] || $past(wr_status)))
      else $error("Suspend flag not held");
   a_config_flag: assert property (
      host_configured |=> flags_q[3])
      else $error("Configuration flag not set");
   a_power_flag: assert property (
      port_power_updated |=> flags_q[2])
      else $error("Port power flag not set");
   a_charger_flag: assert property (
      $fell(charger_found_low) |-> flags_q[1])
      else $error("Charger flag not set on indicator fall");
   a_done_flag: assert property (
      $rose(detect_finished) |=> flags_q[0])
      else $error("Done flag not set");
   a_mask_gate: assert property (
      (!irq_active_q && !(|(ev_set & enable_q))) |=> !irq_active_q)
      else $error("Unenabled event raised interrupt");
   a_irq_hold: assert property (
      (irq_active_q && !wr_status) |=> irq_active_q)
      else $error("Top bit dropped without clear");
   a_addr_select: assert property (
      slave_address == (pin_sync_q[1] ? {6'h14, pin_sync_q[0]} : {6'h04, pin_sync_q[0]}))
      else $error("Slave address wrong");
   a_start_pulse: assert property (
      (chg_det_stage_entry && chg_ctrl_q[4]) |=> detect_start
      ##1 (!detect_start || $past(chg_det_stage_entry) || $past(wait_refclk_stage)))
      else $error("Detection did not start");
   a_cdp_low: assert property (
      (charging_downstream_port && chg_type_q[1]) |=> !charger_found_low)
      else $error("Downstream-port detection ignored");
   a_dcp_low: assert property (
      (dedicated_charging_port && chg_type_q[0]) |=> !charger_found_low)
      else $error("Dedicated-port detection ignored");

   c_irq_raised: cover property (!irq_active_q ##1 irq_active_q);
   c_irq_cleared: cover property (irq_active_q ##1 wr_status ##1 !irq_active_q);
   c_set_clear_race: cover property (wr_status && |ev_set);
   c_charger_found: cover property (detect_start ##[1:20] !charger_found_low);
endmodule
`default_nettype wire

// ### tb_hub_serial_irq_and_charger_cfg.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_hub_serial_irq_and_charger_cfg;
   logic       ref_clk = 1'b0;                  // Hub clock
   logic       rst = 1'b1;                      // Reset
   logic [7:0] reg_addr, reg_wdata, reg_rdata;  // Register port
   logic       reg_wr, reg_rd;                  // Strobes
   logic       hub_in_suspend = 1'b0;           // Event sources
   logic       host_configured = 1'b0, port_power_updated = 1'b0;
   logic       detect_finished = 1'b0, charging_downstream_port = 1'b0;
   logic       dedicated_charging_port = 1'b0, chg_det_stage_entry = 1'b0;
   logic       wait_refclk_stage = 1'b0, ref_clk_absent = 1'b0;
   logic       irq_pin_suspend_level_sel = 1'b0;
   logic       addr_select_lsb_pin = 1'b0, addr_select_msb_pin = 1'b0;
   logic       irq_n, charger_found_low, detect_start, vdat_src_reverse;
   logic       auto_detect_en, enhanced_detect_en;
   logic [6:0] slave_address;                   // Serial address
   logic [7:0] exp_q[$];                        // Expected read data
   logic [7:0] e_rd;                            // Oldest expected read
   int         num_errors = 0;                  // Mismatches
   int         n_checks = 0;                    // Comparisons
   int         n;                               // Pulse count
   // Clock, 25 ns period
   always #12.5 ref_clk = ~ref_clk;
   hsic_host_model host_u (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   hsic_serial_irq dut_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .hub_in_suspend, .host_configured, .port_power_updated,
      .detect_finished, .charging_downstream_port, .dedicated_charging_port,
      .chg_det_stage_entry, .wait_refclk_stage, .ref_clk_absent,
      .irq_pin_suspend_level_sel, .addr_select_lsb_pin, .addr_select_msb_pin,
      .irq_n, .charger_found_low, .detect_start, .vdat_src_reverse,
      .auto_detect_en, .enhanced_detect_en, .slave_address);
   // Watcher: read data settles after the taking edge
   always @(posedge ref_clk) begin
      if (reg_rd === 1'b1) begin
         #2;
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("BAD %0t unexpected read", $time);
         end else begin
            e_rd = exp_q.pop_front();
            `CHK(reg_rdata, e_rd)
         end
      end
   end
   // Note expectation, then read
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_u.rd(a);
   endtask
   // Stage entry (k=0) or refclk wait without clock (k=1); counts start pulses
   task automatic trig(input int k, output int cnt);
      @(posedge ref_clk);
      #1;
      if (k == 1) begin
         wait_refclk_stage = 1'b1;
         ref_clk_absent = 1'b1;
      end else begin
         chg_det_stage_entry = 1'b1;
      end
      cnt = 0;
      repeat (5) begin
         @(posedge ref_clk);
         #1;
         chg_det_stage_entry = 1'b0;
         cnt += int'(detect_start === 1'b1);
      end
      wait_refclk_stage = 1'b0;
      ref_clk_absent = 1'b0;
   endtask
   // Raise one event source; charger events first release the indicator
   task automatic fire(input int i);
      int d;
      if (i == 1 || i == 5) trig(0, d);
      @(posedge ref_clk);
      #1;
      case (i)
         0: detect_finished = 1'b1;
         1: dedicated_charging_port = 1'b1;
         2: port_power_updated = 1'b1;
         3: host_configured = 1'b1;
         4: hub_in_suspend = 1'b1;
         default: charging_downstream_port = 1'b1;
      endcase
      @(posedge ref_clk);
      #1;
      {dedicated_charging_port, port_power_updated, host_configured} = 3'h0;
      {charging_downstream_port, detect_finished, hub_in_suspend} = 3'h0;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   // Verdict and end of run
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #(25 * 20000);
      num_errors++;
      $display("BAD %0t run limit reached", $time);
      conclude();
   end
   // Main sequence
   initial begin
      logic [7:0] r;
      r = 8'($urandom(32'hb7170d43));
      repeat (8) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      chk_rd(8'he8, 8'h00);
      chk_rd(8'he9, 8'h00);
      chk_rd(8'hea, 8'h08);
      chk_rd(8'heb, 8'h28);
      chk_rd(8'hec, 8'h14);
      chk_rd(8'hed, 8'h0f);
      chk_rd(8'hee, 8'h00);
      `CHK(slave_address, 7'h08)
      host_u.wr(8'hea, r);
      chk_rd(8'hea, 8'h08);
      host_u.wr(8'he9, r);
      chk_rd(8'he9, r & 8'h1f);
      host_u.wr(8'hec, ~r);
      chk_rd(8'hec, ~r & 8'h14);
      host_u.wr(8'hec, 8'h14);
      `CHK(vdat_src_reverse, 1'b1)
      host_u.wr(8'hec, 8'h10);
      `CHK(vdat_src_reverse, 1'b0)
      `CHK(auto_detect_en, 1'b1)
      trig(1, n);
      `CHK(n, 1)
      host_u.wr(8'hec, 8'h00);
      trig(0, n);
      `CHK(n, 0)
      host_u.wr(8'hec, 8'h14);
      `CHK(enhanced_detect_en, 1'b1)
      for (int m = 1; m >= 0; m--) begin
         host_u.wr(8'he9, m ? 8'h1f : 8'h00);
         for (int i = 0; i < 5; i++) begin
            fire(i);
            `CHK(irq_n, m ? 1'b0 : 1'b1)
            if (i == 1) `CHK(charger_found_low, 1'b0)
            chk_rd(8'he8, (m ? 8'h80 : 8'h00) | 8'(1 << i));
            host_u.wr(8'he8, 8'hff);
            chk_rd(8'he8, (m ? 8'h80 : 8'h00) | 8'(1 << i));
            host_u.wr(8'he8, 8'h7f);
            `CHK(irq_n, 1'b1)
            host_u.wr(8'he8, 8'h00);
            chk_rd(8'he8, 8'h00);
         end
      end
      host_u.wr(8'hed, 8'h01);
      fire(5);
      `CHK(charger_found_low, 1'b1)
      host_u.wr(8'hed, 8'h0f);
      fire(5);
      `CHK(charger_found_low, 1'b0)
      host_u.wr(8'he8, 8'h00);
      addr_select_msb_pin = 1'b1;
      addr_select_lsb_pin = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK(slave_address, 7'h29)
      irq_pin_suspend_level_sel = 1'b1;
      hub_in_suspend = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(irq_n, 1'b0)
      hub_in_suspend = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(irq_n, 1'b1)
      repeat (3) @(posedge ref_clk);
      conclude();
   end
endmodule
`default_nettype wire
